// >>> verilog/eeprom_page_host.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "eeprom_host_params.svh"
module eeprom_page_host
    import eeprom_host_pkg::*;
#(
    parameter int WC_CYC = `WC_CYCLES,
    parameter int POWERUP_CYC = `POWERUP_CYCLES,
    parameter logic [2:0][14:0] LOCK_ON_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [2:0][7:0] LOCK_ON_DATA = {8'h03, 8'h02, 8'h01},
    parameter logic [2:0][14:0] LOCK_OFF_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [2:0][7:0] LOCK_OFF_DATA = {8'h06, 8'h05, 8'h04}
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [14:0] addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in,
    output logic id_select_address_bit_hv
);
    ctrl_regs_t s;
    ctrl_regs_t next_s;
    eeprom_pins_t pins;
    logic cyc_start;
    logic cyc_write;
    logic [14:0] cyc_addr;
    logic [7:0] cyc_wdata;
    logic [7:0] cyc_rdata;
    logic cyc_done;
    logic cyc_idle;
    logic busy;
    logic [5:0] byte_off;

    function automatic reg_sel_t decode(input logic [11:0] a);
        if (a[1:0] != 2'h0) begin
            return R_NONE;
        end
        if (a[11:8] == 4'(`REG_BUF_BASE >> 8)) begin
            return R_BUF;
        end
        unique case (a)
            `REG_CTRL: return R_CTRL;
            `REG_ADDR: return R_ADDR;
            `REG_COUNT: return R_COUNT;
            `REG_STATUS: return R_STATUS;
            default: return R_NONE;
        endcase
    endfunction : decode

    assign busy = (s.st != ST_IDLE);
    // Page bytes wrap inside one page, upper bits fixed [RULE9] [RULE10]
    assign byte_off = s.addr[5:0] + s.idx[5:0];

    always_comb begin
        cyc_write = 1'b1;
        cyc_addr = {s.addr[14:6], byte_off};
        cyc_wdata = s.page[byte_off];
        unique case (s.st)
            ST_SEQ: begin
                cyc_addr = (s.op == OP_LOCK_OFF) ? LOCK_OFF_ADDR[s.idx[1:0]]
                                                 : LOCK_ON_ADDR[s.idx[1:0]]; // [RULE24]
                cyc_wdata = (s.op == OP_LOCK_OFF) ? LOCK_OFF_DATA[s.idx[1:0]]
                                                  : LOCK_ON_DATA[s.idx[1:0]];
            end
            ST_READ: begin
                cyc_write = 1'b0;
                cyc_addr = s.addr;
            end
            ST_POLL: begin
                cyc_write = 1'b0;
                cyc_addr = s.last_addr;
            end
            default: begin
            end
        endcase
    end

    // Issue the next pin cycle as soon as the previous one ends: bytes follow back to back,
    // well inside the byte-load window, so the device never closes the page early [RULE7]
    assign cyc_start = cyc_idle && !s.pend
        && (s.st == ST_READ || s.st == ST_SEQ || s.st == ST_LOAD || s.st == ST_POLL);

    always_comb begin
        next_s = s;
        pslverr = 1'b0;
        if (psel) begin
            pslverr = (decode(paddr) == R_NONE);
        end
        if (psel && !penable) begin
            unique case (decode(paddr))
                R_CTRL: next_s.prdata = {26'h0, s.id_mode, s.toggle_mode, s.guard, s.op, 1'b0};
                R_ADDR: next_s.prdata = {17'h0, s.addr};
                R_COUNT: next_s.prdata = {25'h0, s.count};
                R_STATUS: next_s.prdata = {16'h0, s.rdata, 3'h0, s.locked,
                    s.st != ST_POWERUP, s.timeout, s.done, busy};
                R_BUF: next_s.prdata = {24'h0, s.page[paddr[7:2]]};
                R_NONE: next_s.prdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite) begin
            unique case (decode(paddr))
                R_STATUS: begin
                    if (pwdata[`STAT_DONE]) begin
                        next_s.done = 1'b0;
                    end
                    if (pwdata[`STAT_TIMEOUT]) begin
                        next_s.timeout = 1'b0;
                    end
                end
                R_ADDR: if (!busy) next_s.addr = pwdata[14:0];
                R_COUNT: if (!busy) next_s.count = pwdata[6:0];
                R_BUF: if (!busy) next_s.page[paddr[7:2]] = pwdata[7:0];
                R_CTRL: begin
                    if (!busy) begin
                        next_s.op = op_t'(pwdata[`CTRL_OP_LO +: 2]);
                        next_s.guard = pwdata[`CTRL_GUARD];
                        next_s.toggle_mode = pwdata[`CTRL_TOGGLE];
                        next_s.id_mode = pwdata[`CTRL_ID];
                        if (pwdata[`CTRL_GO]) begin
                            next_s.idx = 7'h0;
                            next_s.timeout = 1'b0;
                            next_s.hv = pwdata[`CTRL_ID]; // [RULE23]
                            unique case (op_t'(pwdata[`CTRL_OP_LO +: 2]))
                                OP_READ: next_s.st = ST_READ;
                                // A locked part needs the enable bytes first [RULE19]
                                OP_PAGE: next_s.st = (pwdata[`CTRL_GUARD] || s.locked)
                                    ? ST_SEQ : ST_LOAD;
                                OP_LOCK_ON, OP_LOCK_OFF: next_s.st = ST_SEQ; // [RULE17]
                            endcase
                            // Empty page: nothing to load, finish at once
                            if (op_t'(pwdata[`CTRL_OP_LO +: 2]) == OP_PAGE
                                && s.count == 7'h0) begin
                                next_s.st = ST_IDLE;
                                next_s.done = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (cyc_start) begin
            next_s.pend = 1'b1;
        end
        if (s.st == ST_POLL || s.st == ST_WAIT || s.st == ST_POWERUP) begin
            next_s.timer = s.timer + 32'h1;
        end
        unique case (s.st)
            ST_POWERUP: begin
                // No write before the device's power-on delay has run out [RULE14]
                if (s.timer == 32'(POWERUP_CYC - 1)) begin
                    next_s.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
            end
            ST_READ: begin
                if (cyc_done) begin
                    next_s.pend = 1'b0;
                    next_s.rdata = cyc_rdata;
                    next_s.done = 1'b1;
                    next_s.hv = 1'b0;
                    next_s.st = ST_IDLE;
                end
            end
            ST_SEQ: begin
                // Command bytes use page timing; nothing is stored by them [RULE18] [RULE21]
                if (cyc_done) begin
                    next_s.pend = 1'b0;
                    next_s.idx = s.idx + 7'h1;
                    if (s.idx == 7'h2) begin
                        next_s.idx = 7'h0;
                        next_s.timer = 32'h0;
                        next_s.st = (s.op == OP_PAGE) ? ST_LOAD : ST_WAIT;
                    end
                end
            end
            ST_LOAD: begin
                if (cyc_done) begin
                    next_s.pend = 1'b0;
                    next_s.idx = s.idx + 7'h1;
                    next_s.last_addr = {s.addr[14:6], byte_off};
                    next_s.last_data = s.page[byte_off];
                    // Up to one page in a single load, then the device programs [RULE6] [RULE8]
                    if (s.idx + 7'h1 == s.count || s.idx == 7'(`PAGE_BYTES - 1)) begin
                        next_s.timer = 32'h0;
                        next_s.first_poll = 1'b1;
                        next_s.st = ST_POLL;
                    end
                end
            end
            ST_POLL: begin
                if (cyc_done) begin
                    next_s.pend = 1'b0;
                    next_s.rdata = cyc_rdata;
                    next_s.prev = cyc_rdata;
                    next_s.first_poll = 1'b0;
                    // Line 7 true again, or line 6 stops toggling [RULE11] [RULE12] [RULE13]
                    if ((!s.toggle_mode && cyc_rdata[7] == s.last_data[7])
                        || (s.toggle_mode && !s.first_poll && cyc_rdata[6] == s.prev[6])) begin
                        next_s.done = 1'b1;
                        next_s.hv = 1'b0;
                        next_s.st = ST_IDLE;
                    end else if (s.timer >= 32'(WC_CYC)) begin
                        // A locked part ignoring the data still polls for the cycle [RULE22]
                        next_s.timeout = 1'b1;
                        next_s.done = 1'b1;
                        next_s.hv = 1'b0;
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                // Lock change takes effect only after the program cycle time [RULE5] [RULE20]
                if (s.timer == 32'(WC_CYC - 1)) begin
                    next_s.locked = (s.op == OP_LOCK_ON);
                    next_s.done = 1'b1;
                    next_s.hv = 1'b0;
                    next_s.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    eeprom_pin_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(cyc_start),
        .write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .dq_in(dq_in),
        .pins(pins),
        .rdata(cyc_rdata),
        .done(cyc_done),
        .idle(cyc_idle)
    );

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign ce_n = pins.ce_n;
    assign oe_n = pins.oe_n;
    assign we_n = pins.we_n;
    assign addr = pins.addr;
    assign dq_out = pins.dq_out;
    assign dq_oe = pins.dq_oe;
    assign id_select_address_bit_hv = s.hv;
endmodule : eeprom_page_host

// >>> verilog/eeprom_host_params.svh
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH
// Function
// [RULE1] Chip and output enable low, write enable high: device drives the addressed byte.
// [RULE2] Device floats its data lines while chip or output enable is high.
// [RULE3] Write starts on a write or chip enable low pulse; address taken at later fall.
// [RULE4] Device takes write data at the earlier rising edge of chip or write enable.
// [RULE5] Programming self-times; reads give polling status for the whole program cycle time.
// [RULE6] A page load starts like a byte write and carries up to 64 bytes.
// [RULE7] Host presents each further page byte within 150 us of the previous one.
// [RULE8] Without a new byte inside the window, the device stops loading and programs.
// [RULE9] Host keeps address bits 6 to 14 equal for every write strobe of a page.
// [RULE10] Low six address bits pick the byte; any order, overwrites allowed, only loaded ones written.
// [RULE11] While writing, reading the last byte gives its bit 7 inverted on line 7.
// [RULE12] After the cycle, reads give true data; polling may start any time.
// [RULE13] While writing, line 6 toggles on each read; stops once programming ends.
// [RULE14] Device waits about 5 ms after power is good before accepting writes.
// [RULE15] Output enable low, chip enable high or write enable high inhibits writes.
// [RULE16] Strobe pulses shorter than about 15 ns never start a write.
// [RULE17] The soft write lock is user switchable and starts off.
// [RULE18] Three command bytes at three addresses turn the lock on after the cycle time.
// [RULE19] While locked, a write preceded by the same three bytes is still accepted.
// [RULE20] The lock survives power cycles until the disable sequence is sent.
// [RULE21] Command bytes follow page timing, are not stored, addresses stay ordinary.
// [RULE22] Unguarded write while locked starts the timer, stores nothing, reads poll.
// [RULE23] With the id select bit at high voltage, 7FC0H-7FFFH reach the id area.
// [RULE24] Lock command address and data pairs are configurable constants.
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_COUNT 12'h008
`define REG_STATUS 12'h00c
`define REG_BUF_BASE 12'h100
`define CTRL_GO 0
`define CTRL_OP_LO 1
`define CTRL_GUARD 3
`define CTRL_TOGGLE 4
`define CTRL_ID 5
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_TIMEOUT 2
`define STAT_READY 3
`define STAT_LOCKED 4
`define STAT_RDATA_LO 8
`define PAGE_BYTES 64
`define CLK_PERIOD_NS 40
`define T_WP_NS 100
`define T_ACC_NS 120
`define T_DF_NS 50
`define T_BLC_US 150
`define T_WC_MS 10
`define T_POWERUP_MS 5
`define WP_CYCLES ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYCLES ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DF_CYCLES ((`T_DF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLC_CYCLES ((`T_BLC_US * 1000) / `CLK_PERIOD_NS)
`define WC_CYCLES ((`T_WC_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYCLES ((`T_POWERUP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> verilog/eeprom_host_pkg.sv
package eeprom_host_pkg;
    typedef enum logic [1:0] {OP_READ, OP_PAGE, OP_LOCK_ON, OP_LOCK_OFF} op_t;
    typedef enum logic [2:0] {R_CTRL, R_ADDR, R_COUNT, R_STATUS, R_BUF, R_NONE} reg_sel_t;
    typedef enum logic [2:0] {
        ST_POWERUP, ST_IDLE, ST_READ, ST_SEQ, ST_LOAD, ST_POLL, ST_WAIT
    } ctrl_state_t;
    typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} pin_state_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [14:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } eeprom_pins_t;

    typedef struct packed {
        pin_state_t st;
        logic wr;
        logic [3:0] cnt;
        eeprom_pins_t pins;
        logic [7:0] rdata;
        logic done;
    } cycle_regs_t;

    typedef struct packed {
        ctrl_state_t st;
        op_t op;
        logic guard;
        logic toggle_mode;
        logic id_mode;
        logic [14:0] addr;
        logic [6:0] count;
        logic [63:0][7:0] page;
        logic done;
        logic timeout;
        logic locked;
        logic hv;
        logic [7:0] rdata;
        logic [6:0] idx;
        logic pend;
        logic first_poll;
        logic [7:0] prev;
        logic [14:0] last_addr;
        logic [7:0] last_data;
        logic [31:0] timer;
        logic [31:0] prdata;
    } ctrl_regs_t;
endpackage : eeprom_host_pkg

// >>> verilog/eeprom_pin_cycle.sv
`timescale 1ns/10ps
`include "eeprom_host_params.svh"
module eeprom_pin_cycle
    import eeprom_host_pkg::*;
#(
    parameter int WP_CYC = `WP_CYCLES,
    parameter int ACC_CYC = `ACC_CYCLES,
    parameter int DF_CYC = `DF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic write,
    input wire logic [14:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in,
    output eeprom_pins_t pins,
    output logic [7:0] rdata,
    output logic done,
    output logic idle
);
    cycle_regs_t s;
    cycle_regs_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            P_IDLE: begin
                if (start) begin
                    next_s.wr = write;
                    next_s.pins.addr = addr;
                    next_s.pins.dq_out = wdata;
                    // Output enable stays high for a write, so no write is inhibited [RULE15]
                    next_s.pins.dq_oe = write;
                    next_s.pins.ce_n = 1'b0;
                    next_s.pins.oe_n = 1'b1;
                    next_s.st = P_SETUP;
                end
            end
            P_SETUP: begin
                next_s.cnt = 4'h0;
                // Address settles a cycle ahead of the strobe fall [RULE3]
                if (s.wr) begin
                    next_s.pins.we_n = 1'b0;
                end else begin
                    next_s.pins.oe_n = 1'b0; // [RULE1]
                end
                next_s.st = P_STROBE;
            end
            P_STROBE: begin
                next_s.cnt = s.cnt + 4'h1;
                // Whole-cycle strobes, far wider than the noise filter [RULE16]
                if ({28'h0, s.cnt} == 32'(s.wr ? WP_CYC - 1 : ACC_CYC - 1)) begin
                    if (!s.wr) begin
                        next_s.rdata = dq_in;
                    end
                    // Write enable rises first; data still driven on that edge [RULE4]
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.oe_n = 1'b1;
                    next_s.cnt = 4'h0;
                    next_s.st = P_HOLD;
                end
            end
            P_HOLD: begin
                next_s.pins.ce_n = 1'b1;
                next_s.pins.dq_oe = 1'b0;
                next_s.cnt = s.cnt + 4'h1;
                // After a read the device needs time to float its outputs [RULE2]
                if (s.wr || {28'h0, s.cnt} == 32'(DF_CYC - 1)) begin
                    next_s.done = 1'b1;
                    next_s.st = P_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.pins.ce_n <= 1'b1;
            s.pins.oe_n <= 1'b1;
            s.pins.we_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pins = s.pins;
    assign rdata = s.rdata;
    assign done = s.done;
    assign idle = (s.st == P_IDLE);
endmodule : eeprom_pin_cycle

// >>> dv/eeprom_host_monitor.sv
`timescale 1ns/10ps
module eeprom_host_monitor #(
    parameter int POWERUP_CYC = 10
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic [11:0] paddr,
    input logic pslverr,
    input logic ce_n,
    input logic oe_n,
    input logic we_n,
    input logic [14:0] addr,
    input logic [7:0] dq_out,
    input logic dq_oe,
    input logic id_select_address_bit_hv
);
    int unsigned up;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up <= 0;
        else if (up < POWERUP_CYC) up <= up + 1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_strobe_gate: assert property (!we_n |-> !ce_n && oe_n)
        else $error("write strobe outside chip enable");
    chk_pulse_width: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
        else $error("write strobe width wrong");
    chk_data_hold: assert property ($rose(we_n) |-> dq_oe && $stable(dq_out) ##1 ce_n && !dq_oe)
        else $error("data not held past strobe");
    chk_addr_stable: assert property (!ce_n && !$past(ce_n) |-> $stable(addr))
        else $error("address moved under chip enable");
    chk_no_fight: assert property (dq_oe |-> oe_n && !ce_n)
        else $error("host drives data while device may");
    chk_read_pulse: assert property ($fell(oe_n) |-> (!oe_n && !ce_n && we_n) [*3] ##1 oe_n)
        else $error("read strobe wrong");
    chk_powerup_quiet: assert property ($fell(we_n) |-> up >= POWERUP_CYC)
        else $error("write before power up delay");
    chk_id_window: assert property (id_select_address_bit_hv && !ce_n |-> addr[14:6] == 9'h1ff)
        else $error("id select outside id window");
    chk_bad_addr: assert property (psel && paddr[11:8] == 4'h0 && paddr[7:4] != 4'h0 |-> pslverr)
        else $error("unmapped access not flagged");
    cover property ($fell(we_n));
    cover property ($fell(oe_n) && id_select_address_bit_hv);
    cover property (psel && pslverr);
endmodule : eeprom_host_monitor

bind eeprom_page_host eeprom_host_monitor #(.POWERUP_CYC(POWERUP_CYC)) u_eeprom_host_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .paddr(paddr), .pslverr(pslverr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .id_select_address_bit_hv(id_select_address_bit_hv)
);

// >>> dv/eeprom_dev_model.sv
`timescale 1ns/10ps
module eeprom_dev_model #(
    parameter int WC = 12,
    parameter int BLC = 20,
    parameter logic [2:0][14:0] CA = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [2:0][7:0] ON_D = {8'h03, 8'h02, 8'h01},
    parameter logic [2:0][7:0] OFF_D = {8'h06, 8'h05, 8'h04}
) (
    input wire logic pclk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [14:0] addr,
    input wire logic [7:0] dq_out,
    input wire logic hv,
    output logic [7:0] dq_in
);
    logic [7:0] mem [0:32767];
    logic [7:0] idm [0:63];
    logic [14:0] qa [0:66];
    logic [7:0] qd [0:66];
    logic [14:0] la;
    logic [7:0] ld, rd, lastq;
    logic pwe = 1'b1, poe = 1'b1, lock = 1'b0, nl, tog = 1'b0, idw, wr;
    int n = 0, bl = 0, pc = 0, s, pgerr = 0;

    function automatic logic hit(input logic [2:0][7:0] d);
        hit = n >= 3;
        for (int i = 0; i < 3; i++)
            if (hit && (qa[i] != CA[i] || qd[i] != d[i])) hit = 0;
    endfunction : hit

    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (idm[i]) idm[i] = 8'hff;
        ld = 8'h00;
        lastq = 8'h00;
    end
    // Load window counts as busy too, so polling never sees stale data
    always_comb begin
        if (n > 0 || pc > 0) rd = {~ld[7], tog, ld[5:0]};
        else if (hv && addr[14:6] == 9'h1ff) rd = idm[addr[5:0]];
        else rd = mem[addr];
    end
    // Released lines show the inverse of the last driven byte
    assign dq_in = (!ce_n && !oe_n && we_n) ? rd : ~lastq;

    always @(negedge pclk) begin
        if (!ce_n && !oe_n && we_n) lastq = rd;
        if (!poe && oe_n && (n > 0 || pc > 0)) tog = ~tog;
        if (pwe && !we_n && !ce_n && oe_n) la = addr;
        if (!pwe && we_n && !ce_n && oe_n && pc == 0) begin
            if (n >= 4 && la[14:6] != qa[n-1][14:6]) pgerr++;
            qa[n] = la;
            qd[n] = dq_out;
            ld = dq_out;
            idw = hv;
            n++;
            bl = BLC;
        end else if (bl > 0 && --bl == 0) begin
            nl = lock;
            wr = !lock;
            s = 0;
            if (hit(ON_D)) begin
                nl = 1'b1;
                wr = 1'b1;
                s = 3;
            end else if (n == 3 && hit(OFF_D)) begin
                nl = 1'b0;
                s = 3;
            end
            for (int i = s; i < n; i++)
                if (wr && idw) idm[qa[i][5:0]] = qd[i];
                else if (wr) mem[qa[i]] = qd[i];
            n = 0;
            pc = WC;
        end
        if (pc > 0 && --pc == 0) lock = nl;
        pwe = we_n;
        poe = oe_n;
    end
endmodule : eeprom_dev_model

// >>> dv/eeprom_page_host_tb.sv
`timescale 1ns/10ps
module eeprom_page_host_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, s;
    logic pready, pslverr, err, ce_n, oe_n, we_n, dq_oe, hv;
    logic [14:0] addr;
    logic [7:0] dq_out, dq_in;
    int num_errors = 0;
    int checked = 0;

    always #20 pclk = ~pclk;

    eeprom_page_host #(.WC_CYC(200), .POWERUP_CYC(10)) u_eeprom_page_host (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .id_select_address_bit_hv(hv)
    );
    eeprom_dev_model u_eeprom_dev_model (
        .pclk(pclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
        .hv(hv), .dq_in(dq_in)
    );

    task automatic results();
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] dv(input logic [14:0] a);
        return u_eeprom_dev_model.mem[a];
    endfunction : dv

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            results();
        end
        s = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls status until the given bit sets
    task automatic poll(input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, 12'h00c, 32'h0);
            k++;
        end while (s[b] !== 1'b1 && k < 500);
        if (k >= 500) begin
            num_errors++;
            results();
        end
    endtask : poll

    task automatic op(input logic [31:0] c);
        logic [31:0] st;
        apb(1'b1, 12'h000, c);
        poll(1);
        st = s;
        apb(1'b1, 12'h00c, 32'h6);
        s = st;
    endtask : op

    task automatic page(input logic [14:0] a, input int cnt, input logic [31:0] c);
        // Buffer slot is the byte's offset in the page, so wrapped loads land right
        for (int i = 0; i < cnt; i++)
            apb(1'b1, {4'h1, 6'(a[5:0] + 6'(i)), 2'h0}, 32'(8'h21 + i));
        apb(1'b1, 12'h004, {17'h0, a});
        apb(1'b1, 12'h008, 32'(cnt));
        op(c);
    endtask : page

    task automatic rd(input logic [14:0] a, input logic [31:0] c, input logic [7:0] e);
        apb(1'b1, 12'h004, {17'h0, a});
        op(c);
        check("read byte", s[15:8], e);
    endtask : rd

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0);
        check("status at power up", s[4:0], 32'h1);
        poll(3);
        check("status when ready", s[4:0], 32'h8);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped error", err, 1'b1);
        page(15'h0200, 64, 32'h3);
        check("page timeout", s[2], 1'b0);
        for (int i = 0; i < 64; i++) check("page byte", dv(15'h0200 + 15'(i)), 32'(8'h21 + i));
        check("after page", dv(15'h0240), 32'hff);
        rd(15'h023f, 32'h1, 8'h60);
        page(15'h043e, 3, 32'h13);
        check("toggle timeout", s[2], 1'b0);
        check("wrap low", dv(15'h043e), 32'h21);
        check("wrap high", dv(15'h0400), 32'h23);
        check("untouched", dv(15'h0401), 32'hff);
        page(15'h7fc5, 1, 32'h23);
        check("id byte", u_eeprom_dev_model.idm[5], 32'h21);
        check("array beside id", dv(15'h7fc5), 32'hff);
        rd(15'h7fc5, 32'h21, 8'h21);
        op(32'h5);
        apb(1'b0, 12'h00c, 32'h0);
        check("locked", s[4], 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        poll(3);
        check("lock kept", u_eeprom_dev_model.lock, 1'b1);
        page(15'h0600, 1, 32'h3);
        check("refused write", dv(15'h0600), 32'hff);
        check("refused timeout", s[2], 1'b1);
        page(15'h0600, 1, 32'hb);
        check("guarded write", dv(15'h0600), 32'h21);
        check("command byte", dv(15'h0002), 32'hff);
        op(32'h7);
        apb(1'b0, 12'h00c, 32'h0);
        check("unlocked", s[4], 1'b0);
        page(15'h0601, 1, 32'h3);
        check("open write", dv(15'h0601), 32'h21);
        page(15'h0700, 0, 32'h3);
        check("empty page", dv(15'h0700), 32'hff);
        check("page bits", u_eeprom_dev_model.pgerr, 32'h0);
        results();
    end
endmodule : eeprom_page_host_tb
